// file: rtl/ess_map.svh
`ifndef ESS_MAP_SVH
`define ESS_MAP_SVH
`define ESS_HR_STREAMS 12
`define ESS_SPLIT_STREAMS 5
`define ESS_PACK_STREAMS 10
`define ESS_SLOT_BITS 10
`define ESS_HR_SLOTS 64
`define ESS_HR_DIV 8
`define ESS_STATUS_STREAM 11
`define ESS_STATUS_SLOT 6'h00
`define ESS_LOOP_BIT 0
`define ESS_IDLE_WORD 10'h3FF
`define ESS_STATUS_RESET 10'h000
`endif

// file: rtl/ess_pkg.sv
`include "ess_map.svh"
package ess_pkg;
   typedef logic [`ESS_SLOT_BITS-1:0] ess_word_t;
   // Two high-rate slots that together feed one half-rate slot on each split pair.
   typedef struct packed {
      ess_word_t [`ESS_SPLIT_STREAMS-1:0] even_w;
      ess_word_t [`ESS_SPLIT_STREAMS-1:0] odd_w;
   } ess_split_t;
   typedef struct packed {
      logic [`ESS_HR_STREAMS-1:0] data;
      logic [`ESS_HR_STREAMS-1:0] en;
   } ess_hr_tx_t;
endpackage : ess_pkg

// file: rtl/ess_frame_mem.sv
`timescale 1ns/1ps
module ess_frame_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4,
   parameter int AW = 2
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] rdata_reg;

   // Read before write: a location read and written in one cycle returns the old word.
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rdata_reg <= '0;
      end
      else
      begin
         rdata_reg <= mem[raddr];
      end
   end

   assign rdata = rdata_reg;
endmodule : ess_frame_mem

// file: rtl/ess_splitter.sv
`timescale 1ns/1ps
`include "ess_map.svh"
// Summary of operation
// - Any slot whose bit 0 is set, other than the status slot, is looped back toward the main shelf.
// - Five incoming high-rate streams are split into ten half-rate pack streams.
// - Five pairs of half-rate pack streams are merged into five high-rate streams.
// - Merged data reaches the main shelf exactly one frame after arrival.
// - Looped slots return to the main shelf exactly two frames later.
// - Twelve high-rate serial streams run each way between the shelves.
// - The main-shelf activity line makes the pack active or inactive.
// - Status words pass both ways in a fixed slot of the last stream.
module ess_splitter #(
   parameter int HR_DIV = `ESS_HR_DIV,
   parameter int SLOTS = `ESS_HR_SLOTS
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [`ESS_HR_STREAMS-1:0] hr_rx_pin,
   input wire logic frame_pulse_pin,
   input wire logic activity_n_pin,
   input wire logic [`ESS_PACK_STREAMS-1:0] pack_rx_pin,
   input wire logic pack_tx_hold,
   input wire ess_pkg::ess_word_t status_tx_word,
   output ess_pkg::ess_hr_tx_t hr_tx,
   output logic [`ESS_PACK_STREAMS-1:0] pack_tx,
   output logic split_stall,
   output ess_pkg::ess_word_t status_rx_word,
   output logic status_rx_valid
);
   localparam int SB = `ESS_SLOT_BITS;
   localparam int NS = `ESS_HR_STREAMS;
   localparam int NP = `ESS_PACK_STREAMS;
   localparam int NSP = `ESS_SPLIT_STREAMS;
   localparam int SW = $clog2(SLOTS);
   localparam int DW = $clog2(HR_DIV);
   localparam int SYN = NS + NP + 2;
   localparam logic [DW-1:0] DIV_LAST = DW'(HR_DIV - 1);
   localparam logic [3:0] BIT_LAST = 4'(SB - 1);
   localparam logic [SW-1:0] SLOT_LAST = SW'(SLOTS - 1);
   localparam logic [4:0] HALF_LAST = 5'(2 * SB - 1);

   typedef ess_pkg::ess_word_t [NS-1:0] hr_words_t;
   typedef ess_pkg::ess_word_t [NP-1:0] pk_words_t;

   function automatic ess_pkg::ess_word_t shift_in(input ess_pkg::ess_word_t w, input logic b);
      shift_in = {w[SB-2:0], b};
   endfunction : shift_in

   logic [SYN-1:0] sync1_reg, sync2_reg;
   logic fp_d_reg, fp_d_next;
   logic [DW-1:0] div_reg, div_next;
   logic [3:0] bit_reg, bit_next;
   logic [SW-1:0] slot_reg, slot_next;
   logic frame_reg, frame_next;
   logic act_reg, act_next;
   hr_words_t rx_sh_reg, rx_sh_next, tx_sh_reg, tx_sh_next;
   pk_words_t pk_sh_reg, pk_sh_next, ptx_sh_reg, ptx_sh_next;
   ess_pkg::ess_word_t [NSP-1:0] even_reg, even_next;
   ess_pkg::ess_split_t buf_reg [2];
   ess_pkg::ess_split_t buf_next [2];
   logic wptr_reg, wptr_next, rptr_reg, rptr_next;
   logic [1:0] cnt_reg, cnt_next;
   ess_pkg::ess_word_t status_rx_reg, status_rx_next;
   logic status_vld_reg, status_vld_next;

   logic [NS-1:0] rx_bits;
   logic [NP-1:0] pk_bits;
   logic fp_rise, bit_en, slot_end, half_tick, half_end;
   logic [4:0] hpos;
   logic [SW-1:0] ns;
   logic nf;
   hr_words_t rx_done;
   pk_words_t pk_done;
   logic [NS*SB-1:0] loop_rd;
   logic [NP*SB-1:0] conc_rd;
   logic buf_in_ready, buf_out_valid, push, pop;
   ess_pkg::ess_split_t push_data;

   assign rx_bits = sync2_reg[NS-1:0];
   assign pk_bits = sync2_reg[NS+NP-1:NS];
   assign fp_rise = sync2_reg[NS+NP] & ~fp_d_reg;
   assign bit_en = (div_reg == DIV_LAST);
   assign slot_end = bit_en && (bit_reg == BIT_LAST);
   assign hpos = slot_reg[0] ? 5'(SB) + {1'b0, bit_reg} : {1'b0, bit_reg};
   // A half-rate bit spans two high-rate bits, so it is taken at the end of the odd one.
   assign half_tick = bit_en & hpos[0];
   assign half_end = bit_en && (hpos == HALF_LAST);
   assign ns = (slot_reg == SLOT_LAST) ? '0 : slot_reg + SW'(1);
   assign nf = (slot_reg == SLOT_LAST) ? ~frame_reg : frame_reg;
   assign buf_in_ready = (cnt_reg != 2'h2);
   assign buf_out_valid = (cnt_reg != 2'h0);
   assign push_data = '{even_w: even_reg, odd_w: rx_done[NSP-1:0]};
   assign push = slot_end & slot_reg[0] & buf_in_ready;
   // The receiver may hold off; the buffer then fills and raises split_stall.
   assign pop = half_end & buf_out_valid & ~pack_tx_hold;

   always_comb
   begin
      for (int i = 0; i < NS; i++)
      begin
         rx_done[i] = shift_in(rx_sh_reg[i], rx_bits[i]);
      end
      for (int j = 0; j < NP; j++)
      begin
         pk_done[j] = shift_in(pk_sh_reg[j], pk_bits[j]);
      end
   end

   // Looped slots: written at {frame parity, slot}, read one slot ahead at the same parity two frames on.
   ess_frame_mem #(.WIDTH(NS * SB), .DEPTH(2 * SLOTS), .AW(SW + 1)) u_loop_mem (
      .clk(clk),
      .resetn(resetn),
      .we(slot_end),
      .waddr({frame_reg, slot_reg}),
      .wdata(rx_done),
      .raddr({nf, ns}),
      .rdata(loop_rd)
   );

   // Merged pack slots: written during one frame and read back during the next.
   ess_frame_mem #(.WIDTH(NP * SB), .DEPTH(SLOTS), .AW(SW)) u_conc_mem (
      .clk(clk),
      .resetn(resetn),
      .we(half_end),
      .waddr({frame_reg, slot_reg[SW-1:1]}),
      .wdata(pk_done),
      .raddr({~nf, ns[SW-1:1]}),
      .rdata(conc_rd)
   );

   always_comb
   begin
      ess_pkg::ess_word_t lw;
      lw = '0;
      fp_d_next = sync2_reg[NS+NP];
      act_next = ~sync2_reg[NS+NP+1];
      div_next = bit_en ? '0 : div_reg + DW'(1);
      bit_next = bit_reg;
      slot_next = slot_reg;
      frame_next = frame_reg;
      rx_sh_next = rx_sh_reg;
      tx_sh_next = tx_sh_reg;
      pk_sh_next = pk_sh_reg;
      ptx_sh_next = ptx_sh_reg;
      even_next = even_reg;
      status_rx_next = status_rx_reg;
      status_vld_next = 1'b0;
      if (bit_en)
      begin
         bit_next = (bit_reg == BIT_LAST) ? 4'h0 : bit_reg + 4'h1;
         if (bit_reg == BIT_LAST)
         begin
            slot_next = ns;
            frame_next = nf;
         end
         rx_sh_next = rx_done;
         for (int i = 0; i < NS; i++)
         begin
            tx_sh_next[i] = {tx_sh_reg[i][SB-2:0], 1'b1};
         end
      end
      if (slot_end)
      begin
         for (int i = 0; i < NS; i++)
         begin
            lw = loop_rd[i*SB +: SB];
            if (!act_reg)
            begin
               tx_sh_next[i] = `ESS_IDLE_WORD;
            end
            else if (i == `ESS_STATUS_STREAM && ns == SW'(`ESS_STATUS_SLOT))
            begin
               tx_sh_next[i] = status_tx_word;
            end
            else if (lw[`ESS_LOOP_BIT])
            begin
               tx_sh_next[i] = lw;
            end
            else if (i < NSP)
            begin
               tx_sh_next[i] = conc_rd[(2 * i + int'(ns[0])) * SB +: SB];
            end
            else
            begin
               tx_sh_next[i] = `ESS_IDLE_WORD;
            end
         end
         if (!slot_reg[0])
         begin
            even_next = rx_done[NSP-1:0];
         end
         if (slot_reg == SW'(`ESS_STATUS_SLOT))
         begin
            status_rx_next = rx_done[`ESS_STATUS_STREAM];
            status_vld_next = 1'b1;
         end
      end
      if (half_tick)
      begin
         pk_sh_next = pk_done;
         for (int j = 0; j < NP; j++)
         begin
            ptx_sh_next[j] = {ptx_sh_reg[j][SB-2:0], 1'b1};
         end
      end
      if (half_end)
      begin
         for (int i = 0; i < NSP; i++)
         begin
            ptx_sh_next[2*i] = pop ? buf_reg[rptr_reg].even_w[i] : `ESS_IDLE_WORD;
            ptx_sh_next[2*i+1] = pop ? buf_reg[rptr_reg].odd_w[i] : `ESS_IDLE_WORD;
         end
      end
      // The cycle that sees the pulse rise is clock 0 of bit 0, so the divider resumes at 1; parity is left alone.
      if (fp_rise)
      begin
         div_next = DW'(1);
         bit_next = 4'h0;
         slot_next = '0;
      end
   end

   always_comb
   begin
      buf_next = buf_reg;
      wptr_next = wptr_reg;
      rptr_next = rptr_reg;
      cnt_next = cnt_reg;
      if (push)
      begin
         buf_next[wptr_reg] = push_data;
         wptr_next = ~wptr_reg;
      end
      if (pop)
      begin
         rptr_next = ~rptr_reg;
      end
      if (push && !pop)
      begin
         cnt_next = cnt_reg + 2'h1;
      end
      else if (pop && !push)
      begin
         cnt_next = cnt_reg - 2'h1;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_reg <= {SYN{1'b1}};
         sync2_reg <= {SYN{1'b1}};
         fp_d_reg <= 1'b1;
         div_reg <= '0;
         bit_reg <= 4'h0;
         slot_reg <= '0;
         frame_reg <= 1'b0;
         act_reg <= 1'b0;
         rx_sh_reg <= '0;
         tx_sh_reg <= {NS{`ESS_IDLE_WORD}};
         pk_sh_reg <= '0;
         ptx_sh_reg <= {NP{`ESS_IDLE_WORD}};
         even_reg <= '0;
         buf_reg[0] <= '0;
         buf_reg[1] <= '0;
         wptr_reg <= 1'b0;
         rptr_reg <= 1'b0;
         cnt_reg <= 2'h0;
         status_rx_reg <= `ESS_STATUS_RESET;
         status_vld_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= {activity_n_pin, frame_pulse_pin, pack_rx_pin, hr_rx_pin};
         sync2_reg <= sync1_reg;
         fp_d_reg <= fp_d_next;
         div_reg <= div_next;
         bit_reg <= bit_next;
         slot_reg <= slot_next;
         frame_reg <= frame_next;
         act_reg <= act_next;
         rx_sh_reg <= rx_sh_next;
         tx_sh_reg <= tx_sh_next;
         pk_sh_reg <= pk_sh_next;
         ptx_sh_reg <= ptx_sh_next;
         even_reg <= even_next;
         buf_reg <= buf_next;
         wptr_reg <= wptr_next;
         rptr_reg <= rptr_next;
         cnt_reg <= cnt_next;
         status_rx_reg <= status_rx_next;
         status_vld_reg <= status_vld_next;
      end
   end

   always_comb
   begin
      for (int i = 0; i < NS; i++)
      begin
         hr_tx.data[i] = tx_sh_reg[i][SB-1];
      end
      hr_tx.en = {NS{act_reg}};
      for (int j = 0; j < NP; j++)
      begin
         pack_tx[j] = ptx_sh_reg[j][SB-1];
      end
   end

   assign split_stall = ~buf_in_ready;
   assign status_rx_word = status_rx_reg;
   assign status_rx_valid = status_vld_reg;
endmodule : ess_splitter

// file: tb/ess_far_model.sv
`timescale 1ns/1ps
module ess_far_model #(
   parameter int HR_DIV = 8,
   parameter int SLOTS = 64
) (
   input wire logic clk,
   input wire logic resetn,
   input wire ess_pkg::ess_word_t slot_word,
   input wire logic pack_even,
   input wire logic pack_odd,
   output logic [11:0] hr_rx,
   output logic frame_pulse,
   output logic [9:0] pack_rx
);
   int cnt_reg;
   int bit_idx;
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         cnt_reg <= 0;
      else
         cnt_reg <= (cnt_reg == SLOTS * 10 * HR_DIV - 1) ? 0 : cnt_reg + 1;
   assign bit_idx = (cnt_reg / HR_DIV) % 10;
   // Every slot of every stream repeats one word, so counts need no bit alignment.
   assign hr_rx = {12{slot_word[9 - bit_idx]}};
   assign frame_pulse = cnt_reg < HR_DIV;
   assign pack_rx = {5{pack_odd, pack_even}};
endmodule : ess_far_model

// file: tb/ess_splitter_asserts.sv
`timescale 1ns/1ps
`include "ess_map.svh"
module ess_splitter_asserts #(
   parameter int HR_DIV = 8,
   parameter int SLOTS = 64
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic activity_n_pin,
   input wire logic pack_tx_hold,
   input wire ess_pkg::ess_hr_tx_t hr_tx,
   input wire logic [`ESS_PACK_STREAMS-1:0] pack_tx,
   input wire logic split_stall,
   input wire ess_pkg::ess_word_t status_rx_word,
   input wire logic status_rx_valid
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [9:0] hold_reg;
   // The count saturates, so the idle check is blind for HR_DIV above 23.
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         hold_reg <= 10'h000;
      else if (!pack_tx_hold)
         hold_reg <= 10'h000;
      else if (hold_reg != 10'h3FF)
         hold_reg <= hold_reg + 10'h001;
   en_all_same_a: assert property (hr_tx.en == 12'h000 || hr_tx.en == 12'hFFF) else $error("enables differ");
   off_quiet_a: assert property (activity_n_pin [*4] |-> hr_tx.en == 12'h000) else $error("drives inactive");
   on_drive_a: assert property (!activity_n_pin [*4] |-> hr_tx.en == 12'hFFF) else $error("idle when active");
   en_lag_a: assert property ($changed(hr_tx.en) && $past(resetn, 5)
      |-> $past(activity_n_pin, 3) != $past(activity_n_pin, 4)) else $error("enable lag wrong");
   stall_cause_a: assert property ($rose(split_stall) |-> pack_tx_hold) else $error("stall without hold");
   hold_idle_a: assert property (int'(hold_reg) > 44 * HR_DIV |-> pack_tx == 10'h3FF) else $error("data while held");
   status_pulse_a: assert property (status_rx_valid |=> !status_rx_valid [*8]) else $error("valid too long");
   status_cause_a: assert property ($changed(status_rx_word) |-> status_rx_valid) else $error("silent change");
endmodule : ess_splitter_asserts
bind ess_splitter ess_splitter_asserts #(.HR_DIV(HR_DIV), .SLOTS(SLOTS)) u_chk (.clk(clk), .resetn(resetn),
   .activity_n_pin(activity_n_pin), .pack_tx_hold(pack_tx_hold), .hr_tx(hr_tx), .pack_tx(pack_tx),
   .split_stall(split_stall), .status_rx_word(status_rx_word), .status_rx_valid(status_rx_valid));

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
   localparam int DIV = 2;
   localparam int NSL = 4;
   localparam int FR = NSL * 10 * DIV;
   logic clk;
   logic resetn;
   logic act_n;
   logic hold;
   ess_pkg::ess_word_t st_tx;
   ess_pkg::ess_word_t word;
   logic pe;
   logic po;
   logic [11:0] hr_rx;
   logic fp;
   logic [9:0] pack_rx;
   ess_pkg::ess_hr_tx_t hr_tx;
   logic [9:0] pack_tx;
   logic stall;
   ess_pkg::ess_word_t st_rx;
   logic st_v;
   int bad_count;
   int checks_done;
   logic [15:0] ones [12];
   logic [15:0] pk_ones [10];
   logic pk_or;
   ess_far_model #(.HR_DIV(DIV), .SLOTS(NSL)) far (.clk(clk), .resetn(resetn), .slot_word(word), .pack_even(pe),
      .pack_odd(po), .hr_rx(hr_rx), .frame_pulse(fp), .pack_rx(pack_rx));
   ess_splitter #(.HR_DIV(DIV), .SLOTS(NSL)) DUT (.clk(clk), .resetn(resetn), .hr_rx_pin(hr_rx),
      .frame_pulse_pin(fp), .activity_n_pin(act_n), .pack_rx_pin(pack_rx), .pack_tx_hold(hold),
      .status_tx_word(st_tx), .hr_tx(hr_tx), .pack_tx(pack_tx), .split_stall(stall), .status_rx_word(st_rx),
      .status_rx_valid(st_v));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results
   task automatic count_frame();
      pk_or = 1'b0;
      for (int k = 0; k < 12; k++)
         ones[k] = 16'h0000;
      for (int k = 0; k < 10; k++)
         pk_ones[k] = 16'h0000;
      repeat (FR)
      begin
         @(negedge clk);
         for (int k = 0; k < 12; k++)
            ones[k] += 16'(hr_tx.data[k]);
         pk_or |= |pack_tx;
         for (int k = 0; k < 10; k++)
            pk_ones[k] += 16'(pack_tx[k]);
      end
   endtask : count_frame
   task automatic t_inactive();
      repeat (FR) @(posedge clk);
      count_frame();
      check({4'h0, hr_tx.en}, 16'h0000);
      check(ones[0], 16'(FR));
      $display("done inactive");
   endtask : t_inactive
   task automatic t_loop();
      int i;
      @(posedge clk);
      act_n <= 1'b0;
      word <= 10'h001;
      st_tx <= 10'h001;
      repeat (3 * FR) @(posedge clk);
      count_frame();
      check({4'h0, hr_tx.en}, 16'h0FFF);
      for (int k = 0; k < 12; k++)
         check(ones[k], 16'(NSL * DIV));
      for (int k = 0; k < 10; k++)
         check(pk_ones[k], 16'(NSL * DIV));
      for (i = 0; i < FR + 2 && st_v !== 1'b1; i++) @(negedge clk);
      check({5'h00, st_v, st_rx}, 16'h0401);
      $display("done loop");
   endtask : t_loop
   task automatic t_merge();
      @(posedge clk);
      word <= 10'h000;
      st_tx <= 10'h000;
      pe <= 1'b1;
      repeat (3 * FR) @(posedge clk);
      count_frame();
      for (int k = 0; k < 11; k++)
         check(ones[k], 16'(k < 5 ? FR / 2 : FR));
      check(ones[11], 16'(FR - 10 * DIV));
      check({15'h0000, pk_or}, 16'h0000);
      $display("done merge");
   endtask : t_merge
   task automatic t_stall();
      int i;
      @(posedge clk);
      hold <= 1'b1;
      for (i = 0; i < 4 * FR && stall !== 1'b1; i++) @(negedge clk);
      repeat (FR) @(negedge clk);
      check({5'h00, stall, pack_tx}, 16'h07FF);
      @(posedge clk);
      hold <= 1'b0;
      for (i = 0; i < 4 * FR && stall !== 1'b0; i++) @(negedge clk);
      check({15'h0000, stall}, 16'h0000);
      $display("done stall");
   endtask : t_stall
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      resetn = 1'b0;
      act_n = 1'b1;
      hold = 1'b0;
      st_tx = 10'h000;
      word = 10'h000;
      pe = 1'b0;
      po = 1'b0;
      bad_count = 0;
      checks_done = 0;
      repeat (12) @(negedge clk);
      check({3'h0, stall, hr_tx.en}, 16'h0000);
      @(posedge clk);
      resetn <= 1'b1;
      t_inactive();
      t_loop();
      t_merge();
      t_stall();
      results();
   end
   initial
   begin
      repeat (40 * FR) @(posedge clk);
      bad_count++;
      results();
   end
endmodule : tb
